// ### cpc_path_config.sv
// cpc_path_config: codec path configuration register bank with level engines
//
// Overview of operation
// - de-emphasis bit set gives 50/15 us response for 44.1 kHz; clear disables.
// - de-emphasis acts only while single-speed rate range is selected.
// - rate range field bits 7:6: single, double, quad speed; code 11 reserved.
// - capture format bit 4: 0 left-justified, 1 I2S, both up to 24 bits.
// - capture silence bit 2 mutes serial output of both capture channels.
// - offset filter hold bit freezes DC estimate and keeps subtracting it.
// - bit 0 set makes the serial port master, clear makes it slave.
// - master clock divider bits 6:4 select divide by 1, 1.5, 2, 3, 4.
// - playback source bit 7 picks first or second serial data input.
// - loopback bit routes capture data internally to playback input.
// - six-bit gain codes are two's complement in 0.5 dB units.
// - soft ramp steps 1/8 dB each frame period, 1 dB per 8 frames.
// - zero cross applies change on crossing, forced after 512 frames.
// - zero crossing and pending changes are handled per channel.
// - ramp plus zero cross: each 1/8 dB step waits for crossing or timeout.
// - gain mode bits 4:3: immediate, zero cross, ramp, both (default).
// - input select bit 0: 0 microphone level, 1 line level.
// - volume bit 0 adds 0.5 dB, bits 7:1 add whole dB of attenuation.
// - volume changes follow the volume ramp and zero cross bits.
// - while freeze is set, silence, gain and volume writes stay pending.
`timescale 1ns/1ps

module cpc_path_config (
	input wire logic clk_i,
	input wire logic rst_i,
	input cpc_pkg::cpc_wb_req_t wb_i,
	output cpc_pkg::cpc_wb_rsp_t wb_o,
	input wire logic frame_tick_i,
	input wire logic [3:0] zero_cross_i,
	output cpc_pkg::cpc_path_cfg_t cfg_o
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	// channels: 0 left gain, 1 right gain, 2 left volume, 3 right volume
	typedef struct packed {
		logic [15:0][7:0] regs;
		logic live_silence;
		logic [3:0][7:0] live;
		cpc_pkg::cpc_chan_t [3:0] chan;
		logic ack;
		logic [31:0] rdat;
		cpc_pkg::cpc_path_cfg_t cfg;
	} cpc_state_t;

	cpc_state_t s;
	cpc_state_t next_s;
	logic [3:0][9:0] target;
	logic hit;
	logic mapped;
	logic [3:0] idx;

	function automatic cpc_state_t reset_state();
		cpc_state_t r;
		r = '0;
		r.regs[cpc_pkg::IDX_AIN] = cpc_pkg::RST_AIN;
		r.regs[cpc_pkg::IDX_DAC2] = cpc_pkg::RST_DAC2;
		r.cfg.line_input = 1'b1;
		return r;
	endfunction : reset_state

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	always_comb begin
		idx = wb_i.adr[5:2];
		hit = wb_i.cyc & wb_i.stb & ~s.ack;
		mapped = (wb_i.adr[31:6] == 26'h000_0000) && (wb_i.adr[1:0] == 2'b00)
			&& (cpc_pkg::reg_mask(idx) != 8'h00);
	end

	// ----------------------------------------------------------------
	// level targets in 1/8 dB units
	// ----------------------------------------------------------------
	always_comb begin
		// gain: signed half-dB code times four
		target[0] = {{2{s.live[0][5]}}, s.live[0][5:0], 2'b00};
		target[1] = {{2{s.live[1][5]}}, s.live[1][5:0], 2'b00};
		// volume: attenuation, half-dB code times four
		target[2] = {s.live[2], 2'b00};
		target[3] = {s.live[3], 2'b00};
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [9:0] lvl;
		logic [9:0] stepped;
		logic [9:0] nxt;
		logic ramp;
		logic zc;
		logic up;
		lvl = 10'h000;
		stepped = 10'h000;
		nxt = 10'h000;
		ramp = 1'b0;
		zc = 1'b0;
		up = 1'b0;
		next_s = s;

		// single-cycle answer; unmapped reads zero and drops writes
		next_s.ack = hit;
		next_s.rdat = 32'h0000_0000;
		if (hit && mapped) begin
			next_s.rdat = {24'h00_0000, s.regs[idx]};
			if (wb_i.we && wb_i.sel[0]) begin
				next_s.regs[idx] = wb_i.dat[7:0] & cpc_pkg::reg_mask(idx);
			end
		end

		// freeze-able fields move to live copies only while freeze is clear
		if (!s.regs[cpc_pkg::IDX_POWER][cpc_pkg::FREEZE_BIT]) begin
			next_s.live_silence = s.regs[cpc_pkg::IDX_ADC][cpc_pkg::SILENCE_BIT];
			next_s.live[0] = s.regs[cpc_pkg::IDX_LGAIN];
			next_s.live[1] = s.regs[cpc_pkg::IDX_RGAIN];
			next_s.live[2] = s.regs[cpc_pkg::IDX_LVOL];
			next_s.live[3] = s.regs[cpc_pkg::IDX_RVOL];
		end

		// independent engine per channel
		for (int c = 0; c < 4; c++) begin
			lvl = s.chan[c].level;
			if (c < 2) begin
				ramp = s.regs[cpc_pkg::IDX_AIN][cpc_pkg::GAIN_RAMP_BIT];
				zc = s.regs[cpc_pkg::IDX_AIN][cpc_pkg::GAIN_ZC_BIT];
				up = $signed(target[c]) > $signed(lvl);
			end else begin
				ramp = s.regs[cpc_pkg::IDX_DAC2][cpc_pkg::VOL_RAMP_BIT];
				zc = s.regs[cpc_pkg::IDX_DAC2][cpc_pkg::VOL_ZC_BIT];
				up = target[c] > lvl;
			end
			stepped = up ? lvl + 10'h001 : lvl - 10'h001;
			nxt = ramp ? stepped : target[c];
			if (lvl == target[c]) begin
				next_s.chan[c].wait_cnt = 10'h000;
			end else if (zc) begin
				// each change or each step waits for its own crossing
				if (zero_cross_i[c] || s.chan[c].wait_cnt == cpc_pkg::ZC_TIMEOUT_FRAMES) begin
					next_s.chan[c].level = nxt;
					next_s.chan[c].wait_cnt = 10'h000;
				end else if (frame_tick_i) begin
					next_s.chan[c].wait_cnt = s.chan[c].wait_cnt + 10'h001;
				end
			end else if (!ramp || frame_tick_i) begin
				next_s.chan[c].level = nxt;
			end
		end

		// outputs, all held in flops
		next_s.cfg.rate_range = s.regs[cpc_pkg::IDX_ADC][cpc_pkg::RATE_MSB:cpc_pkg::RATE_LSB];
		next_s.cfg.deemphasis_active = s.regs[cpc_pkg::IDX_DAC][cpc_pkg::DEEMPHASIS_ENABLE_BIT]
			&& (s.regs[cpc_pkg::IDX_ADC][cpc_pkg::RATE_MSB:cpc_pkg::RATE_LSB]
			== cpc_pkg::CPC_RATE_SINGLE);
		next_s.cfg.capture_serial_format = s.regs[cpc_pkg::IDX_ADC][cpc_pkg::FORMAT_BIT];
		next_s.cfg.capture_silence = s.live_silence;
		next_s.cfg.offset_filter_hold = s.regs[cpc_pkg::IDX_ADC][cpc_pkg::HOLD_BIT];
		next_s.cfg.master_mode = s.regs[cpc_pkg::IDX_ADC][cpc_pkg::MASTER_BIT];
		// reserved divider codes pass through; the clock tree decides
		next_s.cfg.mclk_divide = s.regs[cpc_pkg::IDX_MCLK][cpc_pkg::MCLK_MSB:cpc_pkg::MCLK_LSB];
		next_s.cfg.playback_source_select = s.regs[cpc_pkg::IDX_ROUTE][cpc_pkg::SOURCE_BIT];
		next_s.cfg.loopback = s.regs[cpc_pkg::IDX_ROUTE][cpc_pkg::LOOP_BIT];
		next_s.cfg.line_input = s.regs[cpc_pkg::IDX_AIN][cpc_pkg::LINE_BIT];
		for (int c = 0; c < 4; c++) begin
			next_s.cfg.level[c] = next_s.chan[c].level;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= reset_state();
		end else begin
			s <= next_s;
		end
	end

	assign wb_o.ack = s.ack;
	assign wb_o.dat = s.rdat;
	assign cfg_o = s.cfg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_ack_one_cycle: assert property (
		s.ack |=> !s.ack
	) else $error("ack held longer than one cycle");

	a_reserved_read_zero: assert property (
		(hit && mapped && !wb_i.we) |=> ((s.rdat[7:0] & ~cpc_pkg::reg_mask($past(idx))) == 8'h00)
			&& (s.rdat[31:8] == 24'h00_0000)
	) else $error("reserved bits read non-zero");

	a_deemphasis_enable_single_only: assert property (
		cfg_o.deemphasis_active |-> (cfg_o.rate_range == cpc_pkg::CPC_RATE_SINGLE)
	) else $error("de-emphasis outside single speed");

	a_deemphasis_enable_follows_bit: assert property (
		(s.regs[cpc_pkg::IDX_DAC][cpc_pkg::DEEMPHASIS_ENABLE_BIT]
			&& s.regs[cpc_pkg::IDX_ADC][7:6] == 2'b00) |=> cfg_o.deemphasis_active
	) else $error("de-emphasis not applied");

	a_config_fields: assert property (
		##1 (cfg_o.master_mode == $past(s.regs[cpc_pkg::IDX_ADC][0]))
			&& (cfg_o.capture_serial_format == $past(s.regs[cpc_pkg::IDX_ADC][4]))
			&& (cfg_o.offset_filter_hold == $past(s.regs[cpc_pkg::IDX_ADC][1]))
			&& (cfg_o.rate_range == $past(s.regs[cpc_pkg::IDX_ADC][7:6]))
			&& (cfg_o.mclk_divide == $past(s.regs[cpc_pkg::IDX_MCLK][6:4]))
			&& (cfg_o.playback_source_select == $past(s.regs[cpc_pkg::IDX_ROUTE][7]))
			&& (cfg_o.loopback == $past(s.regs[cpc_pkg::IDX_ROUTE][1]))
			&& (cfg_o.line_input == $past(s.regs[cpc_pkg::IDX_AIN][0]))
	) else $error("configuration output does not follow register");

	a_freeze_holds_live: assert property (
		$past(s.regs[cpc_pkg::IDX_POWER][7]) |-> ($stable(s.live) && $stable(s.live_silence))
	) else $error("frozen field changed");

	a_release_applies: assert property (
		!s.regs[cpc_pkg::IDX_POWER][7] |=> (s.live[0] == $past(s.regs[cpc_pkg::IDX_LGAIN]))
			&& (s.live_silence == $past(s.regs[cpc_pkg::IDX_ADC][2]))
			##1 (cfg_o.capture_silence == $past(s.live_silence))
	) else $error("pending change not applied on release");

	a_immediate_jump: assert property (
		(!s.regs[cpc_pkg::IDX_AIN][4] && !s.regs[cpc_pkg::IDX_AIN][3])
			|=> (s.chan[0].level == $past(target[0]))
	) else $error("immediate gain change not applied");

	a_ramp_one_step: assert property (
		(s.regs[cpc_pkg::IDX_DAC2][7:6] == 2'b10 && frame_tick_i && s.chan[2].level != target[2])
			|=> (s.chan[2].level == $past(s.chan[2].level) + 10'h001)
			|| (s.chan[2].level == $past(s.chan[2].level) - 10'h001)
	) else $error("ramp step is not 1/8 dB");

	a_ramp_waits_tick: assert property (
		(s.regs[cpc_pkg::IDX_DAC2][7:6] == 2'b10 && !frame_tick_i) |=> $stable(s.chan[2].level)
	) else $error("ramp moved without frame tick");

	a_zc_waits: assert property (
		(s.regs[cpc_pkg::IDX_AIN][3] && !zero_cross_i[1]
			&& s.chan[1].wait_cnt != cpc_pkg::ZC_TIMEOUT_FRAMES) |=> $stable(s.chan[1].level)
	) else $error("gain changed without zero crossing");

	a_zc_timeout_bound: assert property (
		s.chan[3].wait_cnt <= cpc_pkg::ZC_TIMEOUT_FRAMES
	) else $error("zero cross timeout overrun");

	// ----------------------------------------------------------------
	// bus checks
	// ----------------------------------------------------------------
	a_ack_answers: assert property (
		hit |=> s.ack
	) else $error("request not acknowledged next cycle");

	a_ack_needs_request: assert property (
		!(wb_i.cyc && wb_i.stb) |=> !s.ack
	) else $error("ack without request");

	a_rdat_idle_zero: assert property (
		!s.ack |-> (s.rdat == 32'h0000_0000)
	) else $error("read data outside ack");

	a_write_lands: assert property (
		(hit && mapped && wb_i.we && wb_i.sel[0] && idx == cpc_pkg::IDX_LVOL)
			|=> (s.regs[cpc_pkg::IDX_LVOL] == $past(wb_i.dat[7:0]))
	) else $error("write did not land");

	a_reserved_dropped: assert property (
		(hit && mapped && wb_i.we && idx == cpc_pkg::IDX_ADC)
			|=> ((s.regs[cpc_pkg::IDX_ADC] & ~cpc_pkg::reg_mask(cpc_pkg::IDX_ADC)) == 8'h00)
	) else $error("reserved bit stored");

	a_read_returns: assert property (
		(hit && mapped && !wb_i.we && idx == cpc_pkg::IDX_AIN)
			|=> (s.rdat == {24'h00_0000, $past(s.regs[cpc_pkg::IDX_AIN])})
	) else $error("read data differs from register");

	a_unmapped_quiet: assert property (
		(hit && !mapped) |=> (s.rdat == 32'h0000_0000) && $stable(s.regs)
	) else $error("unmapped access had an effect");

	// ----------------------------------------------------------------
	// output and freeze checks
	// ----------------------------------------------------------------
	a_deemphasis_enable_default_off: assert property (
		!s.regs[cpc_pkg::IDX_DAC][cpc_pkg::DEEMPHASIS_ENABLE_BIT] |=> !cfg_o.deemphasis_active
	) else $error("de-emphasis active while bit clear");

	a_deemphasis_enable_rate_gate: assert property (
		(s.regs[cpc_pkg::IDX_ADC][7:6] != 2'b00) |=> !cfg_o.deemphasis_active
	) else $error("de-emphasis active at a fast rate");

	a_silence_frozen_out: assert property (
		$past(s.regs[cpc_pkg::IDX_POWER][cpc_pkg::FREEZE_BIT], 2)
			|-> $stable(cfg_o.capture_silence)
	) else $error("silence output moved while frozen");

	a_live_volume_follows: assert property (
		!s.regs[cpc_pkg::IDX_POWER][cpc_pkg::FREEZE_BIT]
			|=> (s.live[3] == $past(s.regs[cpc_pkg::IDX_RVOL]))
	) else $error("volume not passed on while unfrozen");

	a_live_gain_follows: assert property (
		!s.regs[cpc_pkg::IDX_POWER][cpc_pkg::FREEZE_BIT]
			|=> (s.live[1] == $past(s.regs[cpc_pkg::IDX_RGAIN]))
	) else $error("gain not passed on while unfrozen");

	// ----------------------------------------------------------------
	// level engine checks
	// ----------------------------------------------------------------
	a_gain_ramp_waits: assert property (
		(s.regs[cpc_pkg::IDX_AIN][4:3] == 2'b10 && !frame_tick_i) |=> $stable(s.chan[0].level)
	) else $error("gain ramp moved without frame tick");

	a_gain_ramp_up: assert property (
		(s.regs[cpc_pkg::IDX_AIN][4:3] == 2'b10 && frame_tick_i
			&& $signed(target[0]) > $signed(s.chan[0].level))
			|=> (s.chan[0].level == $past(s.chan[0].level) + 10'h001)
	) else $error("gain ramp step wrong");

	a_gain_zc_left: assert property (
		(s.regs[cpc_pkg::IDX_AIN][4:3] == 2'b01 && zero_cross_i[0])
			|=> (s.chan[0].level == $past(target[0]))
	) else $error("left gain missed its crossing");

	a_gain_zc_right: assert property (
		(s.regs[cpc_pkg::IDX_AIN][4:3] == 2'b01 && zero_cross_i[1])
			|=> (s.chan[1].level == $past(target[1]))
	) else $error("right gain missed its crossing");

	a_zc_timeout_forces: assert property (
		(s.regs[cpc_pkg::IDX_AIN][3] && s.chan[0].level != target[0]
			&& s.chan[0].wait_cnt == cpc_pkg::ZC_TIMEOUT_FRAMES)
			|=> (s.chan[0].wait_cnt == 10'h000) && (s.chan[0].level != $past(s.chan[0].level))
	) else $error("timeout did not force the change");

	a_wait_clears: assert property (
		(s.chan[0].level == target[0]) |=> (s.chan[0].wait_cnt == 10'h000)
	) else $error("timeout count left running");

	a_both_one_step: assert property (
		(s.regs[cpc_pkg::IDX_AIN][4:3] == 2'b11)
			|=> (s.chan[0].level == $past(s.chan[0].level))
			|| (s.chan[0].level == $past(s.chan[0].level) + 10'h001)
			|| (s.chan[0].level == $past(s.chan[0].level) - 10'h001)
	) else $error("combined mode moved more than one step");

	a_vol_immediate: assert property (
		(s.regs[cpc_pkg::IDX_DAC2][7:6] == 2'b00) |=> (s.chan[3].level == $past(target[3]))
	) else $error("immediate volume change not applied");

	a_vol_ramp_down: assert property (
		(s.regs[cpc_pkg::IDX_DAC2][7:6] == 2'b10 && frame_tick_i
			&& target[2] < s.chan[2].level)
			|=> (s.chan[2].level == $past(s.chan[2].level) - 10'h001)
	) else $error("volume ramp step wrong");

	a_vol_zc_jump: assert property (
		(s.regs[cpc_pkg::IDX_DAC2][7:6] == 2'b01 && zero_cross_i[3])
			|=> (s.chan[3].level == $past(target[3]))
	) else $error("right volume missed its crossing");

	a_vol_zc_right: assert property (
		(s.regs[cpc_pkg::IDX_DAC2][7:6] == 2'b01 && !zero_cross_i[3]
			&& s.chan[3].wait_cnt != cpc_pkg::ZC_TIMEOUT_FRAMES) |=> $stable(s.chan[3].level)
	) else $error("right volume changed without crossing");

endmodule : cpc_path_config

// ### cpc_pkg.sv
// cpc_pkg: constants and carrier types of the codec path configuration bank
package cpc_pkg;

	// ----------------------------------------------------------------
	// register indexes (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [3:0] IDX_POWER = 4'h2;
	localparam logic [3:0] IDX_DAC = 4'h3;
	localparam logic [3:0] IDX_ADC = 4'h4;
	localparam logic [3:0] IDX_MCLK = 4'h5;
	localparam logic [3:0] IDX_ROUTE = 4'h6;
	localparam logic [3:0] IDX_RGAIN = 4'h7;
	localparam logic [3:0] IDX_LGAIN = 4'h8;
	localparam logic [3:0] IDX_AIN = 4'h9;
	localparam logic [3:0] IDX_LVOL = 4'ha;
	localparam logic [3:0] IDX_RVOL = 4'hb;
	localparam logic [3:0] IDX_DAC2 = 4'hc;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int FREEZE_BIT = 7;
	localparam int DEEMPHASIS_ENABLE_BIT = 1;
	localparam int RATE_MSB = 7;
	localparam int RATE_LSB = 6;
	localparam int FORMAT_BIT = 4;
	localparam int SILENCE_BIT = 2;
	localparam int HOLD_BIT = 1;
	localparam int MASTER_BIT = 0;
	localparam int MCLK_MSB = 6;
	localparam int MCLK_LSB = 4;
	localparam int SOURCE_BIT = 7;
	localparam int LOOP_BIT = 1;
	localparam int GAIN_RAMP_BIT = 4;
	localparam int GAIN_ZC_BIT = 3;
	localparam int LINE_BIT = 0;
	localparam int VOL_RAMP_BIT = 7;
	localparam int VOL_ZC_BIT = 6;

	// ----------------------------------------------------------------
	// values after reset, counts
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_AIN = 8'h19;
	localparam logic [7:0] RST_DAC2 = 8'hc0;
	localparam logic [9:0] ZC_TIMEOUT_FRAMES = 10'h200;

	typedef enum logic [1:0] {
		CPC_RATE_SINGLE = 2'b00,
		CPC_RATE_DOUBLE = 2'b01,
		CPC_RATE_QUAD = 2'b10,
		CPC_RATE_RSVD = 2'b11
	} cpc_rate_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [31:0] adr;
		logic [31:0] dat;
	} cpc_wb_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} cpc_wb_rsp_t;

	typedef struct packed {
		logic [9:0] level;
		logic [9:0] wait_cnt;
	} cpc_chan_t;

	typedef struct packed {
		logic [1:0] rate_range;
		logic deemphasis_active;
		logic capture_serial_format;
		logic capture_silence;
		logic offset_filter_hold;
		logic master_mode;
		logic [2:0] mclk_divide;
		logic playback_source_select;
		logic loopback;
		logic line_input;
		logic [3:0][9:0] level;
	} cpc_path_cfg_t;

	// writable bits of each register; zero marks an unmapped index
	function automatic logic [7:0] reg_mask(input logic [3:0] idx);
		logic [7:0] m;
		m = 8'h00;
		unique case (idx)
			IDX_POWER: m = 8'h80;
			IDX_DAC: m = 8'h02;
			IDX_ADC: m = 8'hd7;
			IDX_MCLK: m = 8'h70;
			IDX_ROUTE: m = 8'h82;
			IDX_RGAIN, IDX_LGAIN: m = 8'h3f;
			IDX_AIN: m = 8'h19;
			IDX_LVOL, IDX_RVOL: m = 8'hff;
			IDX_DAC2: m = 8'hc0;
			default: m = 8'h00;
		endcase
		return m;
	endfunction : reg_mask

endpackage : cpc_pkg

// ### cpc_path_config_tb.sv
// cpc_path_config_tb: self-checking bench of the path configuration bank
`timescale 1ns/1ps

module cpc_path_config_tb;

	// ----------------------------------------------------------------
	// stimulus and table
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] adr;
		logic [7:0] wdat;
		logic [7:0] rexp;
	} cpc_row_t;

	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	cpc_pkg::cpc_wb_req_t wb_i = '0;
	cpc_pkg::cpc_wb_rsp_t wb_o;
	logic frame_tick_i = 1'b0;
	logic [3:0] zero_cross_i = 4'h0;
	cpc_pkg::cpc_path_cfg_t cfg_o;
	int fails = 0;
	int checked = 0;
	logic [31:0] rd;
	logic [9:0] held;
	// last two rows: unmapped index and misaligned byte address
	cpc_row_t rows [13] = '{'{8'h08, 8'h7f, 8'h00}, '{8'h0c, 8'hff, 8'h02},
		'{8'h10, 8'hff, 8'hd7}, '{8'h14, 8'hff, 8'h70}, '{8'h18, 8'hff, 8'h82},
		'{8'h1c, 8'hff, 8'h3f}, '{8'h20, 8'hff, 8'h3f}, '{8'h24, 8'hff, 8'h19},
		'{8'h28, 8'ha5, 8'ha5}, '{8'h2c, 8'h5a, 8'h5a}, '{8'h30, 8'hff, 8'hc0},
		'{8'h34, 8'hff, 8'h00}, '{8'h11, 8'hff, 8'h00}};

	cpc_path_config cpc_path_config_inst (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_i(wb_i),
		.wb_o(wb_o),
		.frame_tick_i(frame_tick_i),
		.zero_cross_i(zero_cross_i),
		.cfg_o(cfg_o)
	);

	initial begin
		forever #5 clk_i = ~clk_i;
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic stop_test;
		if (fails == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// classic single cycle; held until ack is sampled, never assumes a latency
	task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h1, adr: {24'h00_0000, a},
			dat: {24'h00_0000, d}};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_o.ack !== 1'b1 && n < 20);
		rd = wb_o.dat;
		wb_i <= '0;
		if (wb_o.ack !== 1'b1) begin
			fails++;
			stop_test();
		end
	endtask : wb

	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask : idle

	task automatic tick;
		@(posedge clk_i);
		frame_tick_i <= 1'b1;
		@(posedge clk_i);
		frame_tick_i <= 1'b0;
	endtask : tick

	task automatic zc(input int c);
		@(posedge clk_i);
		zero_cross_i <= 4'h1 << c;
		@(posedge clk_i);
		zero_cross_i <= 4'h0;
		idle(2);
	endtask : zc

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		idle(1);
		chk("line_input", 32'h0000_0001, 32'(cfg_o.line_input));
		for (int i = 2; i < 13; i++) begin
			wb(1'b0, 8'(i * 4), 8'h00);
			chk("reset value", (i == 9) ? 32'h0000_0019 : (i == 12) ? 32'h0000_00c0 : 32'h0000_0000, rd);
		end
		foreach (rows[i]) begin
			wb(1'b1, rows[i].adr, rows[i].wdat);
			wb(1'b0, rows[i].adr, 8'h00);
			chk("readback", {24'h00_0000, rows[i].rexp}, rd);
		end
		idle(2);
		chk("routing", 32'h0000_0007, 32'({cfg_o.playback_source_select, cfg_o.loopback, cfg_o.line_input}));
		// de-emphasis bit stays set from the table while the range sweeps
		for (int i = 0; i < 8; i++) begin
			wb(1'b1, 8'h10, {i[1:0], 6'h00});
			wb(1'b1, 8'h14, {1'b0, i[2:0], 4'h0});
			idle(2);
			chk("rate_range", 32'(i[1:0]), 32'(cfg_o.rate_range));
			chk("deemphasis", 32'(i[1:0] == 2'b00), 32'(cfg_o.deemphasis_active));
			chk("mclk_divide", 32'(i[2:0]), 32'(cfg_o.mclk_divide));
		end
		wb(1'b1, 8'h10, 8'h15);
		idle(3);
		chk("capture bits", 32'h0000_000d, 32'({cfg_o.capture_serial_format, cfg_o.capture_silence,
			cfg_o.offset_filter_hold, cfg_o.master_mode}));
		wb(1'b1, 8'h10, 8'h02);
		idle(3);
		chk("capture bits", 32'h0000_0002, 32'({cfg_o.capture_serial_format, cfg_o.capture_silence,
			cfg_o.offset_filter_hold, cfg_o.master_mode}));
		// gain engine through every change mode
		wb(1'b1, 8'h24, 8'h00);
		wb(1'b1, 8'h20, 8'h28);
		idle(4);
		chk("gain immediate", 32'h0000_03a0, 32'(cfg_o.level[0]));
		wb(1'b1, 8'h24, 8'h10);
		wb(1'b1, 8'h20, 8'h18);
		repeat (10) tick();
		idle(2);
		chk("gain ramp", 32'h0000_03aa, 32'(cfg_o.level[0]));
		wb(1'b1, 8'h24, 8'h08);
		wb(1'b1, 8'h1c, 8'h08);
		zc(1);
		chk("gain zc right", 32'h0000_0020, 32'(cfg_o.level[1]));
		chk("gain zc left", 32'h0000_03aa, 32'(cfg_o.level[0]));
		zc(0);
		chk("gain zc left", 32'h0000_0060, 32'(cfg_o.level[0]));
		wb(1'b1, 8'h20, 8'h00);
		repeat (500) tick();
		idle(2);
		chk("zc waiting", 32'h0000_0060, 32'(cfg_o.level[0]));
		repeat (30) tick();
		idle(2);
		chk("zc timeout", 32'h0000_0000, 32'(cfg_o.level[0]));
		wb(1'b1, 8'h24, 8'h18);
		wb(1'b1, 8'h20, 8'h01);
		zc(0);
		repeat (3) tick();
		idle(2);
		chk("ramp on crossing", 32'h0000_0001, 32'(cfg_o.level[0]));
		// volume, then freeze holding volume and silence together
		wb(1'b1, 8'h30, 8'h00);
		wb(1'b1, 8'h28, 8'hff);
		idle(4);
		chk("volume", 32'h0000_03fc, 32'(cfg_o.level[2]));
		held = cfg_o.level[3];
		wb(1'b1, 8'h08, 8'h80);
		wb(1'b1, 8'h2c, 8'h28);
		wb(1'b1, 8'h10, 8'h04);
		idle(4);
		chk("frozen volume", 32'(held), 32'(cfg_o.level[3]));
		chk("frozen silence", 32'h0000_0000, 32'(cfg_o.capture_silence));
		wb(1'b1, 8'h08, 8'h00);
		idle(4);
		chk("thawed volume", 32'h0000_00a0, 32'(cfg_o.level[3]));
		chk("thawed silence", 32'h0000_0001, 32'(cfg_o.capture_silence));
		// volume ramp only, then right volume on its own crossing
		wb(1'b1, 8'h30, 8'h80);
		wb(1'b1, 8'h28, 8'hfd);
		repeat (3) tick();
		idle(2);
		chk("volume ramp", 32'h0000_03f9, 32'(cfg_o.level[2]));
		wb(1'b1, 8'h30, 8'h40);
		wb(1'b1, 8'h2c, 8'h00);
		zc(3);
		chk("volume zc right", 32'h0000_0000, 32'(cfg_o.level[3]));
		chk("volume zc left", 32'h0000_03f9, 32'(cfg_o.level[2]));
		// mid-run reset restores registers and engines
		rst_i <= 1'b1;
		idle(3);
		rst_i <= 1'b0;
		idle(1);
		chk("reset silence", 32'h0000_0000, 32'(cfg_o.capture_silence));
		chk("reset level", 32'h0000_0000, 32'(cfg_o.level[2]));
		wb(1'b0, 8'h30, 8'h00);
		chk("reset value", 32'h0000_00c0, rd);
		wb(1'b0, 8'h10, 8'h00);
		chk("reset value", 32'h0000_0000, rd);
		stop_test();
	end

endmodule : cpc_path_config_tb
